// file: rtl/gss_auto_start_stop.v
// What this block does
// RL1: Auto, run or stop command puts the control switch into that mode.
// RL2: Auto, run and stop mode outputs are true while switch in mode.
// RL3: Logic remote initiate is ORed with the physical remote initiate pin.
// RL4: Logic emergency stop is ORed with the physical emergency stop pin.
// RL5: Cooldown permit lets the sequencer leave pre-cooldown toward cooldown.
// RL6: With cooldown permit unconnected, pre-cooldown is skipped unless inhibit cooldown is set.
// RL7: With prelube in use, lube override lets the sequencer go to starting.
// RL8: Start aid bypass makes the sequencer skip the start aid timer.
// RL9: Idle command idles the engine when idle support is configured.
// RL10: Inhibit cooldown holds the sequencer in pre-cooldown until released.
// RL11: Crank terminate is true when engine speed exceeds its setpoint.
// RL12: Run state is true while the engine is commanded to start or run.
// RL13: Cooldown state is true while the set is in cooldown.
// RL14: A count of cooldown seconds remaining is output.
// RL15: Sequencer state encodes init through idling as 0 to 8.
// RL16: Fail to start output sets when that event becomes present.
// RL17: Unplanned shutdown output sets when that event becomes present.
// RL18: Timing setpoints are readable copies in seconds.
// RL19: Maximum crank cycles setpoint is readable.
// RL20: Remote control status is true when remote control is enabled.
// RL21: Inputs are sampled on the clock and outputs are registered.
// RL22: Reset gives init state and all boolean outputs low except hreadyout, which resets high.
`timescale 1ns/1ns
`include "gss_defines.vh"

module gss_auto_start_stop #(
  parameter SEC_CYCLES = `GSS_SEC_CYCLES,
  parameter SPEED_W = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire remote_init_pin,
  input wire estop_pin,
  input wire [SPEED_W-1:0] engine_speed,
  input wire [SPEED_W-1:0] crank_term_setpoint,
  output reg auto_mode,
  output reg run_mode,
  output reg stop_mode,
  output reg crank_terminate,
  output reg run_state,
  output reg cooldown_state,
  output reg [15:0] cooldown_remaining,
  output reg [3:0] seq_state,
  output reg idle_mode,
  output reg estop_active,
  output reg start_aid_on,
  output reg fail_to_start_event,
  output reg unplanned_shutdown_event,
  output reg remote_control_enabled
);

  localparam [1:0] SW_STOP = 2'h0;
  localparam [1:0] SW_AUTO = 2'h1;
  localparam [1:0] SW_RUN = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before any logic reads the pins.
  // The pins are asynchronous levels, so only the second flop is read.
  reg rinit_s1_q, rinit_s2_q;
  reg estop_s1_q, estop_s2_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rinit_s1_q <= 1'b0;
      rinit_s2_q <= 1'b0;
      estop_s1_q <= 1'b0;
      estop_s2_q <= 1'b0;
    end else begin
      rinit_s1_q <= remote_init_pin;
      rinit_s2_q <= rinit_s1_q;
      estop_s1_q <= estop_pin;
      estop_s2_q <= estop_s1_q;
    end
  end
  wire rinit_pin_s = rinit_s2_q;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, write data taken in the data phase.
  // The address is held over into the data phase, where the write lands.
  reg wr_pend_q;
  reg [7:0] addr_q;
  reg [13:0] ctrl_q;
  reg [15:0] sp_crank_q, sp_rest_q, sp_delay_q, sp_cool_q;
  reg [15:0] sp_fpd_q, sp_aid_q, sp_maxc_q;
  reg fts_clr_q, uns_clr_q;
  wire addr_ph = hsel & hready & htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= addr_ph & hwrite;
      if (addr_ph) begin
        addr_q <= haddr[7:0];
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Register writes; setpoint copies are loaded by configuration software.
  // The two clear strobes last one cycle and act on the sticky flags.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 14'h0000;
      sp_crank_q <= `GSS_SP_CRANK_RST;
      sp_rest_q <= `GSS_SP_REST_RST;
      sp_delay_q <= `GSS_SP_DELAY_RST;
      sp_cool_q <= `GSS_SP_COOL_RST;
      sp_fpd_q <= `GSS_SP_FPD_RST;
      sp_aid_q <= `GSS_SP_AID_RST;
      sp_maxc_q <= `GSS_SP_MAXC_RST;
      fts_clr_q <= 1'b0;
      uns_clr_q <= 1'b0;
    end else begin
      fts_clr_q <= 1'b0;
      uns_clr_q <= 1'b0;
      if (wr_pend_q) begin
        case (addr_q)
          `GSS_CTRL_OFF: ctrl_q <= hwdata[13:0];
          `GSS_STAT_OFF: begin
            fts_clr_q <= hwdata[16];
            uns_clr_q <= hwdata[17];
          end
          `GSS_SP_CRANK_OFF: sp_crank_q <= hwdata[15:0];
          `GSS_SP_REST_OFF: sp_rest_q <= hwdata[15:0];
          `GSS_SP_DELAY_OFF: sp_delay_q <= hwdata[15:0];
          `GSS_SP_COOL_OFF: sp_cool_q <= hwdata[15:0];
          `GSS_SP_FPD_OFF: sp_fpd_q <= hwdata[15:0];
          `GSS_SP_AID_OFF: sp_aid_q <= hwdata[15:0];
          `GSS_SP_MAXC_OFF: sp_maxc_q <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-second tick for the sequencer timers.
  // A timer started between ticks may run short by up to one tick period.
  reg [31:0] tick_cnt_q;
  reg tick_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= SEC_CYCLES - 1) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Switch mode and combined commands.
  reg [1:0] sw_q;
  wire estop_any = ctrl_q[`GSS_C_ESTOP] | estop_s2_q; // RL4
  wire rinit_any = ctrl_q[`GSS_C_RINIT] | rinit_pin_s; // RL3
  wire over_crank = engine_speed > crank_term_setpoint; // RL11
  // Stop outranks run and run outranks auto, so a held stop always wins.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_q <= SW_STOP;
    end else if (ctrl_q[`GSS_C_STOP]) begin
      sw_q <= SW_STOP; // RL1
    end else if (ctrl_q[`GSS_C_RUN]) begin
      sw_q <= SW_RUN; // RL1
    end else if (ctrl_q[`GSS_C_AUTO]) begin
      sw_q <= SW_AUTO; // RL1
    end
  end
  // Run is wanted in run mode, or in auto mode with a remote initiate, and never during an emergency stop.
  wire want_run = !estop_any &&
                  (sw_q == SW_RUN || (sw_q == SW_AUTO && rinit_any));

  ////////////////////////////////////////////////////////////////////////
  // Sequencer with a seconds timer and crank attempt counter.
  reg [3:0] st_q;
  reg [15:0] tmr_q;
  reg [15:0] cranks_q;
  reg resting_q;
  reg fts_q, uns_q;
  wire tmr_done = (tmr_q == 16'h0000);
  // Without a wired permit source the permit is taken as given.
  wire permit_ok = !ctrl_q[`GSS_C_PERMIT_CON] | ctrl_q[`GSS_C_PERMIT];
  // Prelube only holds the start back when prelube is in use.
  wire lube_ok = !ctrl_q[`GSS_C_PRELUBE_EN] | ctrl_q[`GSS_C_LUBE];
  // Start delay plus start aid time; both are small second counts.
  wire [15:0] aid_time = ctrl_q[`GSS_C_AIDBYP] ? 16'h0000 : sp_aid_q; // RL8
  wire [16:0] precrank_sum = {1'b0, sp_delay_q} + {1'b0, aid_time};
  // Failure to start: the last crank ran out without crank terminate.
  wire fts_set = st_q == `GSS_ST_STARTING && !resting_q && tmr_done &&
                 tick_q && !over_crank && cranks_q + 16'h0001 >= sp_maxc_q;
  // Unplanned shutdown: speed fell away while the engine was still wanted.
  wire uns_set = st_q == `GSS_ST_RUNNING && want_run && !over_crank;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= `GSS_ST_INIT; // RL22
      tmr_q <= 16'h0000;
      cranks_q <= 16'h0000;
      resting_q <= 1'b0;
    end else if (estop_any) begin
      // Emergency stop wins over every state; the crank count is kept.
      st_q <= `GSS_ST_STOPPED;
      tmr_q <= 16'h0000;
    end else begin
      if (tick_q && !tmr_done) begin
        tmr_q <= tmr_q - 16'h0001;
      end
      case (st_q)
        // Init lasts a single cycle after reset.
        `GSS_ST_INIT: st_q <= `GSS_ST_STOPPED;
        // Stopped: a run request starts the delay and start aid timer.
        `GSS_ST_STOPPED: if (want_run) begin
          st_q <= `GSS_ST_PRECRANK;
          tmr_q <= precrank_sum[15:0]; // RL8
        end
        // Pre-crank: wait out the timer and, when in use, the prelube.
        `GSS_ST_PRECRANK: if (!want_run) begin
          st_q <= `GSS_ST_STOPPED;
        end else if (tmr_done && lube_ok) begin // RL7
          st_q <= `GSS_ST_STARTING;
          tmr_q <= sp_crank_q;
          cranks_q <= 16'h0000;
          resting_q <= 1'b0;
        end
        // Starting: alternate crank and rest periods until speed is reached.
        `GSS_ST_STARTING: if (!want_run) begin
          st_q <= `GSS_ST_STOPPING;
        end else if (over_crank) begin
          st_q <= `GSS_ST_RUNNING;
        end else if (fts_set) begin
          st_q <= `GSS_ST_STOPPED;
        end else if (tmr_done && tick_q) begin
          resting_q <= !resting_q;
          tmr_q <= resting_q ? sp_crank_q : sp_rest_q;
          if (!resting_q) begin
            cranks_q <= cranks_q + 16'h0001;
          end
        end
        // Running: leave for cooldown, for idle or, on a stall, for stopped.
        `GSS_ST_RUNNING: if (uns_set) begin
          st_q <= `GSS_ST_STOPPED;
        end else if (!want_run) begin
          st_q <= permit_ok && !ctrl_q[`GSS_C_INHIBIT] ?
                  `GSS_ST_COOL : `GSS_ST_PRECOOL; // RL6
          tmr_q <= sp_cool_q;
        end else if (ctrl_q[`GSS_C_IDLE] && ctrl_q[`GSS_C_IDLE_SUP]) begin
          st_q <= `GSS_ST_IDLING; // RL9
        end
        // Idling: a stop goes toward cooldown just as from running.
        `GSS_ST_IDLING: if (!want_run) begin
          st_q <= permit_ok && !ctrl_q[`GSS_C_INHIBIT] ?
                  `GSS_ST_COOL : `GSS_ST_PRECOOL; // RL6
          tmr_q <= sp_cool_q;
        end else if (!ctrl_q[`GSS_C_IDLE]) begin
          st_q <= `GSS_ST_RUNNING;
        end
        // Pre-cooldown: hold until permitted and no longer inhibited.
        `GSS_ST_PRECOOL: if (want_run) begin
          st_q <= `GSS_ST_RUNNING;
        end else if (permit_ok && !ctrl_q[`GSS_C_INHIBIT]) begin
          st_q <= `GSS_ST_COOL; // RL5 RL10
          tmr_q <= sp_cool_q;
        end
        // Cooldown: count the cooldown time down, or resume on a run request.
        `GSS_ST_COOL: if (want_run) begin
          st_q <= `GSS_ST_RUNNING;
        end else if (tmr_done) begin
          st_q <= `GSS_ST_STOPPING;
        end
        // Stopping: wait for the engine to fall below crank terminate speed.
        `GSS_ST_STOPPING: if (!over_crank) begin
          st_q <= `GSS_ST_STOPPED;
        end
        default: st_q <= `GSS_ST_INIT;
      endcase
    end
  end

  // Sticky event flags; a new event wins over a clear in the same cycle.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fts_q <= 1'b0;
      uns_q <= 1'b0;
    end else begin
      fts_q <= fts_set | (fts_q & !fts_clr_q); // RL16
      uns_q <= uns_set | (uns_q & !uns_clr_q); // RL17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered status outputs, all low after reset.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_mode <= 1'b0; // RL22
      run_mode <= 1'b0;
      stop_mode <= 1'b0;
      crank_terminate <= 1'b0;
      run_state <= 1'b0;
      cooldown_state <= 1'b0;
      cooldown_remaining <= 16'h0000;
      seq_state <= `GSS_ST_INIT;
      idle_mode <= 1'b0;
      estop_active <= 1'b0;
      start_aid_on <= 1'b0;
      fail_to_start_event <= 1'b0;
      unplanned_shutdown_event <= 1'b0;
      remote_control_enabled <= 1'b0;
    end else begin
      auto_mode <= sw_q == SW_AUTO; // RL2 RL21
      run_mode <= sw_q == SW_RUN; // RL2
      stop_mode <= sw_q == SW_STOP; // RL2
      crank_terminate <= over_crank; // RL11
      run_state <= st_q == `GSS_ST_STARTING || st_q == `GSS_ST_RUNNING ||
                   st_q == `GSS_ST_IDLING; // RL12
      cooldown_state <= st_q == `GSS_ST_COOL; // RL13
      cooldown_remaining <= st_q == `GSS_ST_COOL ? tmr_q : 16'h0000; // RL14
      seq_state <= st_q; // RL15
      idle_mode <= st_q == `GSS_ST_IDLING; // RL9
      estop_active <= estop_any; // RL4
      start_aid_on <= st_q == `GSS_ST_PRECRANK && !ctrl_q[`GSS_C_AIDBYP] &&
                      !tmr_done; // RL8
      fail_to_start_event <= fts_q; // RL16
      unplanned_shutdown_event <= uns_q; // RL17
      remote_control_enabled <= ctrl_q[`GSS_C_REMOTE_EN]; // RL20
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data mux, unmapped addresses read zero.
  // Decoded from the address phase so the data phase sees it at once.
  reg [31:0] rd_d;
  always @* begin
    case (haddr[7:0])
      `GSS_CTRL_OFF: rd_d = {18'h00000, ctrl_q};
      `GSS_STAT_OFF: rd_d = {14'h0000, uns_q, fts_q, 8'h00,
                             estop_any, over_crank, sw_q, st_q};
      `GSS_COOL_OFF: rd_d = {16'h0000, cooldown_remaining}; // RL14
      `GSS_SP_CRANK_OFF: rd_d = {16'h0000, sp_crank_q}; // RL18
      `GSS_SP_REST_OFF: rd_d = {16'h0000, sp_rest_q}; // RL18
      `GSS_SP_DELAY_OFF: rd_d = {16'h0000, sp_delay_q}; // RL18
      `GSS_SP_COOL_OFF: rd_d = {16'h0000, sp_cool_q}; // RL18
      `GSS_SP_FPD_OFF: rd_d = {16'h0000, sp_fpd_q}; // RL18
      `GSS_SP_AID_OFF: rd_d = {16'h0000, sp_aid_q}; // RL18
      `GSS_SP_MAXC_OFF: rd_d = {16'h0000, sp_maxc_q}; // RL19
      default: rd_d = 32'h00000000;
    endcase
  end

  // Read data is registered at the address-phase edge for the data phase.
  // A read right after a write to the same register sees the old value.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ph && !hwrite) begin
      hrdata <= rd_d; // RL21
    end
  end

endmodule // gss_auto_start_stop

// file: common/gss_defines.vh
`ifndef GSS_DEFINES_VH
`define GSS_DEFINES_VH
// Register byte offsets.
`define GSS_CTRL_OFF 8'h00
`define GSS_STAT_OFF 8'h04
`define GSS_COOL_OFF 8'h08
`define GSS_SP_CRANK_OFF 8'h0c
`define GSS_SP_REST_OFF 8'h10
`define GSS_SP_DELAY_OFF 8'h14
`define GSS_SP_COOL_OFF 8'h18
`define GSS_SP_FPD_OFF 8'h1c
`define GSS_SP_AID_OFF 8'h20
`define GSS_SP_MAXC_OFF 8'h24
// Control register fields.
`define GSS_C_AUTO 0
`define GSS_C_RUN 1
`define GSS_C_STOP 2
`define GSS_C_RINIT 3
`define GSS_C_ESTOP 4
`define GSS_C_PERMIT 5
`define GSS_C_PERMIT_CON 6
`define GSS_C_LUBE 7
`define GSS_C_AIDBYP 8
`define GSS_C_IDLE 9
`define GSS_C_INHIBIT 10
`define GSS_C_PRELUBE_EN 11
`define GSS_C_IDLE_SUP 12
`define GSS_C_REMOTE_EN 13
// Setpoint reset values, seconds, and crank cycles for the maximum.
`define GSS_SP_CRANK_RST 16'h000a
`define GSS_SP_REST_RST 16'h000a
`define GSS_SP_DELAY_RST 16'h0000
`define GSS_SP_COOL_RST 16'h012c
`define GSS_SP_FPD_RST 16'h000a
`define GSS_SP_AID_RST 16'h0000
`define GSS_SP_MAXC_RST 16'h0003
// Sequencer encodings.
`define GSS_ST_INIT 4'h0
`define GSS_ST_PRECRANK 4'h1
`define GSS_ST_STARTING 4'h2
`define GSS_ST_RUNNING 4'h3
`define GSS_ST_PRECOOL 4'h4
`define GSS_ST_COOL 4'h5
`define GSS_ST_STOPPING 4'h6
`define GSS_ST_STOPPED 4'h7
`define GSS_ST_IDLING 4'h8
// Clock rate and the one-second tick.
`define GSS_CLK_HZ 100000000
`define GSS_SEC_CYCLES (`GSS_CLK_HZ * 1)
`endif

// file: verification/gss_chk_sva.sv
`timescale 1ns/1ns
`include "gss_defines.vh"
// Ties the sequencer outputs to their causes at the ports.
module gss_chk #(
  parameter SPEED_W = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire estop_pin,
  input wire [SPEED_W-1:0] engine_speed,
  input wire [SPEED_W-1:0] crank_term_setpoint,
  input wire auto_mode,
  input wire run_mode,
  input wire stop_mode,
  input wire crank_terminate,
  input wire run_state,
  input wire cooldown_state,
  input wire [15:0] cooldown_remaining,
  input wire [3:0] seq_state,
  input wire estop_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_MODE_ONE:
  assert property ($onehot0({auto_mode, run_mode, stop_mode}))
    else $error("Switch modes overlap.");
  AST_RUN_ST:
  assert property (seq_state == `GSS_ST_STARTING |-> ##[0:2] run_state)
    else $error("Run state low while starting.");
  AST_COOL_ST:
  assert property (seq_state == `GSS_ST_COOL |-> ##[0:2] cooldown_state)
    else $error("Cooldown state low in cooldown.");
  AST_CT_ON:
  assert property (engine_speed > crank_term_setpoint |-> ##[1:2]
    crank_terminate) else $error("Crank terminate missed.");
  AST_CT_OFF:
  assert property (engine_speed <= crank_term_setpoint |-> ##[1:2]
    !crank_terminate) else $error("Crank terminate false.");
  AST_ENC:
  assert property (seq_state <= `GSS_ST_IDLING)
    else $error("State code out of range.");
  AST_REMAIN:
  assert property ((seq_state != `GSS_ST_COOL) [*3] |->
    cooldown_remaining == 16'h0000) else $error("Countdown outside cooldown.");
  AST_ESTOP:
  assert property (estop_pin |-> ##[1:4] estop_active)
    else $error("Stop pin ignored.");
  AST_ESTOP_RUN:
  assert property (estop_active |-> ##[0:3] !run_state)
    else $error("Engine commanded during stop.");
endmodule // gss_chk
bind gss_auto_start_stop gss_chk #(.SPEED_W(SPEED_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .estop_pin(estop_pin),
  .engine_speed(engine_speed), .crank_term_setpoint(crank_term_setpoint),
  .auto_mode(auto_mode), .run_mode(run_mode), .stop_mode(stop_mode),
  .crank_terminate(crank_terminate), .run_state(run_state),
  .cooldown_state(cooldown_state), .cooldown_remaining(cooldown_remaining),
  .seq_state(seq_state), .estop_active(estop_active));

// file: verification/gss_engine_model.sv
`timescale 1ns/1ns
module gss_engine_model (
  input wire hclk,
  input wire hresetn,
  input wire run_state,
  input wire cooldown_state,
  input wire stall,
  output reg [15:0] engine_speed
);
  // Spins up while commanded or cooling down, coasts down when stalled.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      engine_speed <= 16'h0000;
    end else if ((run_state || cooldown_state) && !stall) begin
      if (engine_speed < 16'h0800) begin
        engine_speed <= engine_speed + 16'h0040;
      end
    end else if (engine_speed != 16'h0000) begin
      engine_speed <= engine_speed - 16'h0040;
    end
  end
endmodule // gss_engine_model

// file: verification/tb_top.sv
`timescale 1ns/1ns
`include "gss_defines.vh"
module tb_top;
  reg hclk, hresetn, hsel, hwrite, remote_init_pin, estop_pin, stall;
  reg [31:0] haddr, hwdata, rdv;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [15:0] crank_term_setpoint;
  reg [9:0] seen;
  reg [111:0] sp_rst;
  wire [31:0] hrdata;
  wire hreadyout, hresp, auto_mode, run_mode, stop_mode, crank_terminate;
  wire run_state, cooldown_state, idle_mode, estop_active, start_aid_on;
  wire fail_to_start_event, unplanned_shutdown_event, remote_control_enabled;
  wire [15:0] engine_speed, cooldown_remaining;
  wire [3:0] seq_state;
  wire [31:0] st;
  integer mismatches, cmp_count, cyc, i;
  assign st = {cooldown_remaining, remote_control_enabled, idle_mode,
    unplanned_shutdown_event, fail_to_start_event, estop_active,
    crank_terminate, cooldown_state, run_state, 1'b0, stop_mode, run_mode,
    auto_mode, seq_state};
  gss_auto_start_stop #(.SEC_CYCLES(10)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .remote_init_pin(remote_init_pin),
    .estop_pin(estop_pin), .engine_speed(engine_speed),
    .crank_term_setpoint(crank_term_setpoint), .auto_mode(auto_mode),
    .run_mode(run_mode), .stop_mode(stop_mode),
    .crank_terminate(crank_terminate), .run_state(run_state),
    .cooldown_state(cooldown_state), .cooldown_remaining(cooldown_remaining),
    .seq_state(seq_state), .idle_mode(idle_mode), .estop_active(estop_active),
    .start_aid_on(start_aid_on), .fail_to_start_event(fail_to_start_event),
    .unplanned_shutdown_event(unplanned_shutdown_event),
    .remote_control_enabled(remote_control_enabled));
  gss_engine_model u_eng (.hclk(hclk), .hresetn(hresetn),
    .run_state(run_state), .cooldown_state(cooldown_state), .stall(stall),
    .engine_speed(engine_speed));
  ////////////////////////////////////////////////////////////
  // One single AHB transfer; read data lands in rdv.
  task bus(input [31:0] a, input w, input [31:0] wd);
    begin
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdv = hrdata;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // Waits up to n cycles for the masked status, sampled at falling edges.
  task wt(input [31:0] m, input [31:0] v, input integer n);
    integer k;
    begin
      k = 0;
      @(negedge hclk);
      while ((st & m) !== v && k < n) begin
        @(negedge hclk);
        k = k + 1;
      end
      chk("status", v, st & m);
      @(posedge hclk);
    end
  endtask
  task final_report;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Clock of 10 ns.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Records visited states and start aid activity, plus the hang limit.
  always @(negedge hclk) begin
    seen[seq_state] <= 1'b1;
    if (start_aid_on) seen[9] <= 1'b1;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      final_report;
    end
  end
  // Main sequence.
  initial begin
    {hresetn, hsel, hwrite, remote_init_pin, estop_pin, stall} = 6'h10;
    {haddr, hwdata, htrans, hsize, seen} = 0;
    hsize = 3'h2;
    crank_term_setpoint = 16'h0200;
    sp_rst = {16'h3, 16'h0, 16'ha, 16'h12c, 16'h0, 16'ha, 16'ha};
    {mismatches, cmp_count, cyc} = 0;
    repeat (15) @(posedge hclk);
    wt(32'hffffffff, 32'h0, 0);
    hresetn <= 1'b1;
    wt(32'hf, 32'h7, 4);
    for (i = 0; i < 7; i = i + 1) begin
      bus(32'h0c + 4 * i, 1'b0, 32'h0);
      chk("setpoint", {16'h0, sp_rst[16*i +: 16]}, rdv);
    end
    bus(32'h40, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rdv);
    bus(32'h0c, 1'b1, 32'h2);
    bus(32'h10, 1'b1, 32'h1);
    bus(32'h18, 1'b1, 32'h3);
    bus(32'h20, 1'b1, 32'h1);
    bus(32'h18, 1'b0, 32'h0);
    chk("setpoint", 32'h3, rdv);
    for (i = 0; i < 3; i = i + 1) begin
      bus(32'h0, 1'b1, 32'h1 << ((i * 2) % 3));
      wt(32'h70, 32'h10 << ((i * 2) % 3), 5);
    end
    wt(32'h50f, 32'h503, 300);
    chk("aid", 32'h1, {31'h0, seen[9]});
    seen = 10'h0;
    bus(32'h0, 1'b1, 32'h4);
    wt(32'hffff020f, 32'h30205, 40);
    wt(32'hffff0000, 32'h10000, 30);
    wt(32'hf, 32'h7, 60);
    chk("precool", 32'h0, {31'h0, seen[4]});
    bus(32'h0, 1'b1, 32'h2);
    wt(32'hf, 32'h3, 300);
    bus(32'h0, 1'b1, 32'h464);
    repeat (40) @(posedge hclk);
    wt(32'hf, 32'h4, 0);
    bus(32'h0, 1'b1, 32'h64);
    wt(32'hf, 32'h5, 10);
    wt(32'hf, 32'h7, 100);
    seen = 10'h0;
    bus(32'h0, 1'b1, 32'h101);
    remote_init_pin <= 1'b1;
    wt(32'h10f, 32'h103, 300);
    chk("aid", 32'h0, {31'h0, seen[9]});
    estop_pin <= 1'b1;
    wt(32'h80f, 32'h807, 10);
    {estop_pin, remote_init_pin} <= 2'h0;
    bus(32'h0, 1'b1, 32'h9);
    wt(32'h10f, 32'h103, 300);
    bus(32'h0, 1'b1, 32'h19);
    wt(32'h80f, 32'h807, 10);
    bus(32'h0, 1'b1, 32'h2a02);
    repeat (60) @(posedge hclk);
    wt(32'h800f, 32'h8001, 0);
    bus(32'h0, 1'b1, 32'h2a82);
    wt(32'hf, 32'h3, 300);
    wt(32'h400f, 32'h3, 0);
    bus(32'h0, 1'b1, 32'h3a82);
    wt(32'h400f, 32'h4008, 20);
    bus(32'h0, 1'b1, 32'h4);
    wt(32'hf, 32'h7, 100);
    stall <= 1'b1;
    bus(32'h0, 1'b1, 32'h2);
    wt(32'h1000, 32'h1000, 600);
    bus(32'h0, 1'b1, 32'h4);
    bus(32'h4, 1'b1, 32'h10000);
    wt(32'h1000, 32'h0, 5);
    stall <= 1'b0;
    bus(32'h0, 1'b1, 32'h2);
    wt(32'hf, 32'h3, 300);
    stall <= 1'b1;
    wt(32'h2000, 32'h2000, 100);
    final_report;
  end
endmodule // tb_top
